// ---- logic/dcsra_map.vh ----
// Purpose: Constants for the dual channel serial register access block.
// Assumes: Included by the register access design files.
// Notes:   Register numbers are the pointer values seen by the host.
`ifndef DCSRA_MAP_VH
`define DCSRA_MAP_VH
`define DCSRA_REG_CMD      4'h0
`define DCSRA_REG_IRQEN    4'h1
`define DCSRA_REG_VECTOR   4'h2
`define DCSRA_REG_RXPAR    4'h3
`define DCSRA_REG_MODES    4'h4
`define DCSRA_REG_TXPAR    4'h5
`define DCSRA_REG_SYNC1    4'h6
`define DCSRA_REG_SYNC2    4'h7
`define DCSRA_REG_DATA     4'h8
`define DCSRA_REG_MASTER   4'h9
`define DCSRA_REG_MISC     4'ha
`define DCSRA_REG_CLKMODE  4'hb
`define DCSRA_REG_TCLO     4'hc
`define DCSRA_REG_TCHI     4'hd
`define DCSRA_REG_MISCCTL  4'he
`define DCSRA_REG_EXTCTL   4'hf
`define DCSRA_PTR_LSB      0
`define DCSRA_PTR_MSB      2
`define DCSRA_CMD_LSB      3
`define DCSRA_CMD_MSB      5
`define DCSRA_CMD_PTHIGH   3'h1
`define DCSRA_CMD_RSTEXT   3'h2
`define DCSRA_RST_VALUE    8'h00
`define DCSRA_RECOVER_NS   200
`define DCSRA_CLK_NS       50
`define DCSRA_RECOVER_CYC  ((`DCSRA_RECOVER_NS + `DCSRA_CLK_NS - 1) / `DCSRA_CLK_NS)
`define DCSRA_FIFO_DEPTH   4
`define DCSRA_RXQ_DEPTH    3
`define DCSRA_SYNC_STAGES  3
`endif

// ---- logic/dcsra_fifo.v ----
// Purpose: Small valid/ready FIFO used in the transmit path.
// Assumes: Single clock, asynchronous active low reset.
// Notes:   Full and empty are exact; data is read from the head entry.
`timescale 1ns/10ps
module dcsra_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    rd_ff;
  reg [AW-1:0]    wr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ff];
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ff  <= {AW{1'b0}};
      wr_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_ff] <= in_data;
        wr_ff      <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                 rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // dcsra_fifo

// ---- logic/dcsra_channel.v ----
// Purpose: One serial channel register set with its data buffering.
// Assumes: Host access strobes are already synchronised, one cycle long.
// Notes:   Instantiated once per channel by the top module.
`timescale 1ns/10ps
`include "dcsra_map.vh"
module dcsra_channel (
  input  wire       clk,
  input  wire       rstn,
  input  wire       wr_stb,
  input  wire       rd_stb,
  input  wire [3:0] reg_sel,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  input  wire [7:0] rx_char,
  input  wire       rx_valid,
  output wire       rx_ready,
  output wire [7:0] tx_char,
  output wire       tx_valid,
  input  wire       tx_ready,
  input  wire [7:0] ext_status,
  input  wire [7:0] rx_err,
  output wire [7:0] modes_out,
  output wire [7:0] sync_out,
  output wire [15:0] tc_out
);
  reg  [7:0] wreg_ff [0:15];
  reg  [7:0] rxq_ff  [0:2];
  reg  [1:0] rxq_cnt_ff;
  reg  [7:0] rx_shift_ff;
  reg        rx_full_ff;
  wire       data_wr;
  wire       data_rd;
  wire       tx_in_ready;
  wire [2:0] tx_level;
  integer    i;

  assign data_wr  = wr_stb & (reg_sel == `DCSRA_REG_DATA);
  assign data_rd  = rd_stb & (reg_sel == `DCSRA_REG_DATA);
  assign rx_ready = ~rx_full_ff;
  assign modes_out = wreg_ff[`DCSRA_REG_MODES];
  assign sync_out  = wreg_ff[`DCSRA_REG_SYNC1];
  assign tc_out    = {wreg_ff[`DCSRA_REG_TCHI], wreg_ff[`DCSRA_REG_TCLO]};

  // Transmit data buffer ahead of the link, full stalls nothing upstream.
  dcsra_fifo #(.WIDTH(8), .DEPTH(`DCSRA_FIFO_DEPTH), .AW(2)) u_txq (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (data_wr),
    .in_ready  (tx_in_ready),
    .in_data   (wdata),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_char),
    .level     (tx_level)
  );

  // Receive path: shift holding register then three entry queue.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_shift_ff <= `DCSRA_RST_VALUE;
      rx_full_ff  <= 1'b0;
      rxq_cnt_ff  <= 2'h0;
      for (i = 0; i < 3; i = i + 1) begin
        rxq_ff[i] <= `DCSRA_RST_VALUE;
      end
    end else begin
      if (rx_valid & ~rx_full_ff) begin
        rx_shift_ff <= rx_char;
        rx_full_ff  <= 1'b1;
      end else if (rx_full_ff & (rxq_cnt_ff != 2'h3) & ~data_rd) begin
        rxq_ff[rxq_cnt_ff] <= rx_shift_ff;
        rxq_cnt_ff         <= rxq_cnt_ff + 2'h1;
        rx_full_ff         <= 1'b0;
      end
      if (data_rd & (rxq_cnt_ff != 2'h0)) begin
        rxq_ff[0]  <= rxq_ff[1];
        rxq_ff[1]  <= rxq_ff[2];
        rxq_cnt_ff <= rxq_cnt_ff - 2'h1;
      end
    end
  end

  // Write registers; number 8 goes to the transmit buffer instead.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 16; i = i + 1) begin
        wreg_ff[i] <= `DCSRA_RST_VALUE;
      end
    end else if (wr_stb & (reg_sel != `DCSRA_REG_DATA)) begin
      wreg_ff[reg_sel] <= wdata;
    end
  end

  // Read registers are status sources separate from the write registers, except 12, 13 and 15.
  always @* begin
    case (reg_sel)
      4'h0:    rdata = {ext_status[7:3], tx_in_ready,
                        ext_status[1], (rxq_cnt_ff != 2'h0)};
      4'h1:    rdata = rx_err;
      4'h8:    rdata = rxq_ff[0];
      4'ha:    rdata = {5'h00, tx_level};
      4'hc:    rdata = wreg_ff[`DCSRA_REG_TCLO];
      4'hd:    rdata = wreg_ff[`DCSRA_REG_TCHI];
      4'hf:    rdata = wreg_ff[`DCSRA_REG_EXTCTL] & 8'hfa;
      default: rdata = 8'h00;
    endcase
  end
endmodule // dcsra_channel

// ---- logic/dcsra_top.v ----
// Purpose: Host bus register access for a two channel serial controller.
// Assumes: Host strobes are asynchronous to CLK and spaced four clocks.
// Notes:   Serial engines attach on the character stream ports.
`timescale 1ns/10ps
`include "dcsra_map.vh"
module dcsra_top (
  input  wire        CLK,
  input  wire        RSTN,
  input  wire        CS_N,
  input  wire        RD_N,
  input  wire        WR_N,
  input  wire        CHAN_B,
  input  wire        DATA_SEL,
  input  wire [7:0]  DIN,
  output reg  [7:0]  DOUT,
  output reg         DOUT_EN,
  input  wire [7:0]  RXA_CHAR,
  input  wire        RXA_VALID,
  output reg         RXA_READY,
  input  wire [7:0]  RXB_CHAR,
  input  wire        RXB_VALID,
  output reg         RXB_READY,
  output reg  [7:0]  TXA_CHAR,
  output reg         TXA_VALID,
  input  wire        TXA_READY,
  output reg  [7:0]  TXB_CHAR,
  output reg         TXB_VALID,
  input  wire        TXB_READY,
  input  wire [7:0]  RXA_ERR,
  input  wire [7:0]  RXB_ERR,
  input  wire [3:0]  MODEM_A,
  input  wire [3:0]  MODEM_B,
  input  wire [5:0]  IRQ_PENDING,
  output reg  [15:0] TC_A,
  output reg  [15:0] TC_B,
  output reg  [7:0]  MASTER_CTL,
  output reg  [7:0]  VECTOR_OUT
);
  reg  [2:0]  rd_sync_ff;
  reg  [2:0]  wr_sync_ff;
  reg         rd_act_ff;
  reg         wr_act_ff;
  reg  [3:0]  modem_a_s1_ff;
  reg  [3:0]  modem_a_s2_ff;
  reg  [3:0]  modem_a_s3_ff;
  reg  [3:0]  modem_a_ff;
  reg  [3:0]  modem_b_s1_ff;
  reg  [3:0]  modem_b_s2_ff;
  reg  [3:0]  modem_b_s3_ff;
  reg  [3:0]  modem_b_ff;
  reg  [9:0]  bus_s1_ff;
  reg  [9:0]  bus_s2_ff;
  reg  [9:0]  bus_s3_ff;
  reg  [9:0]  bus_hold_ff;
  reg  [3:0]  ptr_ff;
  reg  [3:0]  nxt_ptr;
  reg  [7:0]  vector_ff;
  reg  [7:0]  master_ff;
  reg  [7:0]  nxt_dout;
  reg  [2:0]  gap_ff;
  wire        rd_fall;
  wire        wr_fall;
  wire        rd_stb;
  wire        wr_stb;
  wire [3:0]  reg_sel;
  wire [3:0]  cmd_ptr;
  wire [2:0]  cmd_code;
  wire        shared_sel;
  wire        wr_a;
  wire        wr_b;
  wire        rd_a;
  wire        rd_b;
  wire [7:0]  rdata_a;
  wire [7:0]  rdata_b;
  wire [7:0]  rxa_q;
  wire [7:0]  rxb_q;
  wire        rxa_rdy;
  wire        rxb_rdy;
  wire [7:0]  txa_q;
  wire [7:0]  txb_q;
  wire        txa_v;
  wire        txb_v;
  wire [15:0] tca_q;
  wire [15:0] tcb_q;
  wire [7:0]  ext_a;
  wire [7:0]  ext_b;
  wire [9:0]  bus_q;
  wire        bus_chan_b;
  wire        bus_dsel;
  wire [7:0]  bus_din;

  localparam integer RECOVER_I = `DCSRA_RECOVER_CYC - 1;

  // Strobe synchronisers: three stages, a change counts when 2 and 3 agree.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_sync_ff    <= 3'h7;
      wr_sync_ff    <= 3'h7;
      rd_act_ff     <= 1'b0;
      wr_act_ff     <= 1'b0;
      modem_a_s1_ff <= 4'h0;
      modem_a_s2_ff <= 4'h0;
      modem_a_s3_ff <= 4'h0;
      modem_a_ff    <= 4'h0;
      modem_b_s1_ff <= 4'h0;
      modem_b_s2_ff <= 4'h0;
      modem_b_s3_ff <= 4'h0;
      modem_b_ff    <= 4'h0;
      bus_s1_ff     <= 10'h000;
      bus_s2_ff     <= 10'h000;
      bus_s3_ff     <= 10'h000;
      bus_hold_ff   <= 10'h000;
    end else begin
      rd_sync_ff    <= {rd_sync_ff[1:0], ~(~RD_N & ~CS_N)};
      wr_sync_ff    <= {wr_sync_ff[1:0], ~(~WR_N & ~CS_N)};
      if (rd_sync_ff[1] == rd_sync_ff[2]) begin
        rd_act_ff <= ~rd_sync_ff[2];
      end
      if (wr_sync_ff[1] == wr_sync_ff[2]) begin
        wr_act_ff <= ~wr_sync_ff[2];
      end
      modem_a_s1_ff <= MODEM_A;
      modem_a_s2_ff <= modem_a_s1_ff;
      modem_a_s3_ff <= modem_a_s2_ff;
      modem_a_ff    <= (modem_a_s2_ff & modem_a_s3_ff) |
                       (modem_a_ff & (modem_a_s2_ff | modem_a_s3_ff));
      modem_b_s1_ff <= MODEM_B;
      modem_b_s2_ff <= modem_b_s1_ff;
      modem_b_s3_ff <= modem_b_s2_ff;
      modem_b_ff    <= (modem_b_s2_ff & modem_b_s3_ff) |
                       (modem_b_ff & (modem_b_s2_ff | modem_b_s3_ff));
      bus_s1_ff     <= {CHAN_B, DATA_SEL, DIN};
      bus_s2_ff     <= bus_s1_ff;
      bus_s3_ff     <= bus_s2_ff;
      if (bus_s2_ff == bus_s3_ff) begin
        bus_hold_ff <= bus_s3_ff;
      end
    end
  end

  assign rd_fall = (rd_sync_ff[1] == rd_sync_ff[2]) & ~rd_sync_ff[2] &
                   ~rd_act_ff;
  assign wr_fall = (wr_sync_ff[1] == wr_sync_ff[2]) & ~wr_sync_ff[2] &
                   ~wr_act_ff;
  // Bus qualifiers pass the same three stages as the strobes.
  assign bus_q      = (bus_s2_ff == bus_s3_ff) ? bus_s3_ff : bus_hold_ff;
  assign bus_chan_b = bus_q[9];
  assign bus_dsel   = bus_q[8];
  assign bus_din    = bus_q[7:0];

  // Accesses arriving inside the recovery gap are dropped.
  assign rd_stb  = rd_fall & (gap_ff == 3'h0);
  assign wr_stb  = wr_fall & (gap_ff == 3'h0);

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap_ff <= 3'h0;
    end else if (rd_stb | wr_stb) begin
      gap_ff <= RECOVER_I[2:0];
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
    end
  end

  // Data select bypasses the pointer, otherwise the pending pointer applies.
  assign reg_sel  = bus_dsel ? `DCSRA_REG_DATA : ptr_ff;
  assign cmd_ptr  = {1'b0, bus_din[`DCSRA_PTR_MSB:`DCSRA_PTR_LSB]};
  assign cmd_code = bus_din[`DCSRA_CMD_MSB:`DCSRA_CMD_LSB];
  assign shared_sel = (reg_sel == `DCSRA_REG_VECTOR) |
                      (reg_sel == `DCSRA_REG_MASTER);
  assign wr_a = wr_stb & ~bus_chan_b & ~shared_sel;
  assign wr_b = wr_stb &  bus_chan_b & ~shared_sel;
  assign rd_a = rd_stb & ~bus_chan_b;
  assign rd_b = rd_stb &  bus_chan_b;

  // Pointer: set by a register zero write, cleared after the next access made without data select.
  always @* begin
    nxt_ptr = ptr_ff;
    if ((rd_stb | wr_stb) & ~bus_dsel) begin
      if (wr_stb & (ptr_ff == `DCSRA_REG_CMD)) begin
        nxt_ptr = cmd_ptr;
        if (cmd_code == `DCSRA_CMD_PTHIGH) begin
          nxt_ptr = cmd_ptr + 4'h8;
        end
      end else begin
        nxt_ptr = `DCSRA_REG_CMD;
      end
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_ff    <= `DCSRA_REG_CMD;
      vector_ff <= `DCSRA_RST_VALUE;
      master_ff <= `DCSRA_RST_VALUE;
    end else begin
      ptr_ff <= nxt_ptr;
      if (wr_stb & (reg_sel == `DCSRA_REG_VECTOR)) begin
        vector_ff <= bus_din;
      end
      if (wr_stb & (reg_sel == `DCSRA_REG_MASTER)) begin
        master_ff <= bus_din;
      end
    end
  end

  assign ext_a = {modem_a_ff, 1'b0, 1'b0, 1'b0, 1'b0};
  assign ext_b = {modem_b_ff, 1'b0, 1'b0, 1'b0, 1'b0};

  // Two identical channels.
  dcsra_channel u_chan_a (
    .clk        (CLK),
    .rstn       (RSTN),
    .wr_stb     (wr_a),
    .rd_stb     (rd_a),
    .reg_sel    (reg_sel),
    .wdata      (bus_din),
    .rdata      (rdata_a),
    .rx_char    (RXA_CHAR),
    .rx_valid   (RXA_VALID),
    .rx_ready   (rxa_rdy),
    .tx_char    (txa_q),
    .tx_valid   (txa_v),
    .tx_ready   (TXA_READY & TXA_VALID),
    .ext_status (ext_a),
    .rx_err     (RXA_ERR),
    .modes_out  (),
    .sync_out   (),
    .tc_out     (tca_q)
  );

  dcsra_channel u_chan_b (
    .clk        (CLK),
    .rstn       (RSTN),
    .wr_stb     (wr_b),
    .rd_stb     (rd_b),
    .reg_sel    (reg_sel),
    .wdata      (bus_din),
    .rdata      (rdata_b),
    .rx_char    (RXB_CHAR),
    .rx_valid   (RXB_VALID),
    .rx_ready   (rxb_rdy),
    .tx_char    (txb_q),
    .tx_valid   (txb_v),
    .tx_ready   (TXB_READY & TXB_VALID),
    .ext_status (ext_b),
    .rx_err     (RXB_ERR),
    .modes_out  (),
    .sync_out   (),
    .tc_out     (tcb_q)
  );

  // Read data mux, with the shared vector register and register 3 resolved here; master reads come from the channel as zero.
  always @* begin
    nxt_dout = bus_chan_b ? rdata_b : rdata_a;
    if (reg_sel == `DCSRA_REG_VECTOR) begin
      nxt_dout = bus_chan_b ? {vector_ff[7:4], IRQ_PENDING[2:0], vector_ff[0]}
                            : vector_ff;
    end else if (reg_sel == `DCSRA_REG_RXPAR) begin
      nxt_dout = bus_chan_b ? 8'h00 : {2'h0, IRQ_PENDING};
    end
  end

  // Outputs are registered; read data is held while the read lasts.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DOUT       <= 8'h00;
      DOUT_EN    <= 1'b0;
      RXA_READY  <= 1'b0;
      RXB_READY  <= 1'b0;
      TXA_CHAR   <= 8'h00;
      TXA_VALID  <= 1'b0;
      TXB_CHAR   <= 8'h00;
      TXB_VALID  <= 1'b0;
      TC_A       <= 16'h0000;
      TC_B       <= 16'h0000;
      MASTER_CTL <= 8'h00;
      VECTOR_OUT <= 8'h00;
    end else begin
      if (rd_stb) begin
        DOUT    <= nxt_dout;
        DOUT_EN <= 1'b1;
      end else if (rd_sync_ff[1] & rd_sync_ff[2]) begin
        DOUT_EN <= 1'b0;
      end
      RXA_READY  <= rxa_rdy;
      RXB_READY  <= rxb_rdy;
      TXA_CHAR   <= txa_q;
      TXA_VALID  <= txa_v & ~(TXA_VALID & TXA_READY);
      TXB_CHAR   <= txb_q;
      TXB_VALID  <= txb_v & ~(TXB_VALID & TXB_READY);
      TC_A       <= tca_q;
      TC_B       <= tcb_q;
      MASTER_CTL <= master_ff;
      VECTOR_OUT <= vector_ff;
    end
  end
endmodule // dcsra_top

// ---- tb/dcsra_monitor.sv ----
// Purpose: Port level checks of the register access block.
// Assumes: Bound to the top module, one clock domain.
// Notes:   Host strobes are held at least three clocks.
`timescale 1ns/10ps
module dcsra_monitor (
  input logic        CLK,
  input logic        RSTN,
  input logic        CS_N,
  input logic        RD_N,
  input logic        WR_N,
  input logic        CHAN_B,
  input logic [7:0]  DOUT,
  input logic        DOUT_EN,
  input logic [7:0]  TXA_CHAR,
  input logic        TXA_VALID,
  input logic        TXA_READY,
  input logic [15:0] TC_A,
  input logic [15:0] TC_B,
  input logic [7:0]  MASTER_CTL,
  input logic [7:0]  VECTOR_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_rd_idle; RD_N [*5]; endsequence
  sequence s_tx_wait; TXA_VALID && !TXA_READY; endsequence
  property p_rst; $rose(RSTN) |-> TC_A == 0 && TC_B == 0 &&
    MASTER_CTL == 0 && VECTOR_OUT == 0 && !DOUT_EN; endproperty
  property p_en_rise; $rose(DOUT_EN) |-> $past(!CS_N && !RD_N, 2);
  endproperty
  property p_en_drop; s_rd_idle |=> !DOUT_EN; endproperty
  property p_dout; $changed(DOUT) |-> $past(!RD_N, 2); endproperty
  property p_tca; $changed(TC_A) |-> $past(!CS_N && !WR_N && !CHAN_B, 2);
  endproperty
  property p_tcb; $changed(TC_B) |-> $past(!CS_N && !WR_N && CHAN_B, 2);
  endproperty
  property p_mst; $changed(MASTER_CTL) |-> $past(!CS_N && !WR_N, 2);
  endproperty
  property p_vec; $changed(VECTOR_OUT) |-> $past(!CS_N && !WR_N, 2);
  endproperty
  property p_txdrop; TXA_VALID && TXA_READY |=> !TXA_VALID; endproperty
  property p_txhold; s_tx_wait |=> TXA_VALID && $stable(TXA_CHAR);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  a_en_rise: assert property (p_en_rise) else $error("enable early");
  a_en_drop: assert property (p_en_drop) else $error("enable held");
  a_dout: assert property (p_dout) else $error("read data moved");
  a_tca: assert property (p_tca) else $error("TC_A moved");
  a_tcb: assert property (p_tcb) else $error("TC_B moved");
  a_mst: assert property (p_mst) else $error("master moved");
  a_vec: assert property (p_vec) else $error("vector moved");
  a_txdrop: assert property (p_txdrop) else $error("tx valid held");
  a_txhold: assert property (p_txhold) else $error("tx char lost");
endmodule // dcsra_monitor

// ---- tb/dcsra_host.sv ----
// Purpose: Host processor model for the parallel register bus.
// Assumes: Inputs of the device are sampled on the rising edge.
// Notes:   Data lines show the inverse of the last value when released.
`timescale 1ns/10ps
module dcsra_host (
  input  logic       CLK,
  input  logic [7:0] DOUT,
  output logic       CS_N,
  output logic       RD_N,
  output logic       WR_N,
  output logic       CHAN_B,
  output logic       DATA_SEL,
  output logic [7:0] DIN
);
  initial begin
    {CS_N, RD_N, WR_N, CHAN_B, DATA_SEL} = 5'h1c;
    DIN = 8'h00;
  end
  // One bus cycle; the strobe falls nine clocks apart.
  task acc(input logic r, input logic ch, input logic ds,
           input logic [7:0] d, output logic [7:0] q);
    @(negedge CLK);
    CHAN_B = ch;
    DATA_SEL = ds;
    DIN = r ? ~DIN : d;
    CS_N = 1'b0;
    RD_N = !r;
    WR_N = r;
    repeat (6) @(negedge CLK);
    q = DOUT;
    CS_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    DIN = ~DIN;
    repeat (2) @(negedge CLK);
  endtask
endmodule // dcsra_host

// ---- tb/dcsra_top_tb.sv ----
// Purpose: Self-checking bench of the register access block.
// Assumes: Host model issues every bus cycle.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/10ps
module dcsra_top_tb;
  logic        CLK, RSTN, CS_N, RD_N, WR_N, CHAN_B, DATA_SEL, DOUT_EN;
  logic        RXA_VALID, RXA_READY, RXB_VALID, RXB_READY;
  logic        TXA_VALID, TXA_READY, TXB_VALID, TXB_READY;
  logic [7:0]  DIN, DOUT, RXA_CHAR, RXB_CHAR, TXA_CHAR, TXB_CHAR, got;
  logic [7:0]  RXA_ERR, RXB_ERR, MASTER_CTL, VECTOR_OUT;
  logic [3:0]  MODEM_A, MODEM_B;
  logic [5:0]  IRQ_PENDING;
  logic [15:0] TC_A, TC_B;
  int          num_errors, num_checks;
  dcsra_host host (.CLK(CLK), .DOUT(DOUT), .CS_N(CS_N), .RD_N(RD_N),
    .WR_N(WR_N), .CHAN_B(CHAN_B), .DATA_SEL(DATA_SEL), .DIN(DIN));
  dcsra_top uut (.CLK(CLK), .RSTN(RSTN), .CS_N(CS_N), .RD_N(RD_N),
    .WR_N(WR_N), .CHAN_B(CHAN_B), .DATA_SEL(DATA_SEL), .DIN(DIN),
    .DOUT(DOUT), .DOUT_EN(DOUT_EN), .RXA_CHAR(RXA_CHAR),
    .RXA_VALID(RXA_VALID), .RXA_READY(RXA_READY), .RXB_CHAR(RXB_CHAR),
    .RXB_VALID(RXB_VALID), .RXB_READY(RXB_READY), .TXA_CHAR(TXA_CHAR),
    .TXA_VALID(TXA_VALID), .TXA_READY(TXA_READY), .TXB_CHAR(TXB_CHAR),
    .TXB_VALID(TXB_VALID), .TXB_READY(TXB_READY), .RXA_ERR(RXA_ERR),
    .RXB_ERR(RXB_ERR), .MODEM_A(MODEM_A), .MODEM_B(MODEM_B),
    .IRQ_PENDING(IRQ_PENDING), .TC_A(TC_A), .TC_B(TC_B),
    .MASTER_CTL(MASTER_CTL), .VECTOR_OUT(VECTOR_OUT));
  task test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic ch, input logic ds, input logic [7:0] d);
    host.acc(1'b0, ch, ds, d, got);
  endtask
  task rd(input logic ch, input logic ds);
    host.acc(1'b1, ch, ds, 8'h00, got);
  endtask
  // Pointer bits 2:0 plus the point-high command in bits 5:3.
  task regwr(input logic ch, input logic [3:0] r, input logic [7:0] d);
    wr(ch, 1'b0, {4'h0, r});
    wr(ch, 1'b0, d);
  endtask
  task regrd(input logic ch, input logic [3:0] r);
    wr(ch, 1'b0, {4'h0, r});
    rd(ch, 1'b0);
  endtask
  task push(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge CLK);
    RXA_CHAR = c;
    RXA_VALID = 1'b1;
    while (RXA_READY !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    @(negedge CLK);
    RXA_VALID = 1'b0;
  endtask
  task take(input logic [7:0] e);
    int n;
    n = 0;
    while (TXA_VALID !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    chk("tx char", {8'h00, e}, {8'h00, TXA_CHAR});
    TXA_READY = 1'b1;
    @(negedge CLK);
    TXA_READY = 1'b0;
    @(negedge CLK);
  endtask
  task t_tc;
    chk("TC_A", 16'h0000, TC_A);
    chk("DOUT_EN", 16'h0000, {15'h0, DOUT_EN});
    regwr(1'b0, 4'hc, 8'h34);
    regwr(1'b0, 4'hd, 8'h12);
    regwr(1'b1, 4'hc, 8'hab);
    chk("TC_A", 16'h1234, TC_A);
    chk("TC_B", 16'h00ab, TC_B);
    regrd(1'b0, 4'hc);
    chk("tc low", 16'h0034, {8'h00, got});
    regrd(1'b0, 4'hd);
    chk("tc high", 16'h0012, {8'h00, got});
  endtask
  task t_ctl;
    rd(1'b0, 1'b0);
    chk("reg0", 16'h0094, {8'h00, got & 8'hf5});
    regrd(1'b0, 4'h1);
    chk("reg1", 16'h0061, {8'h00, got});
    rd(1'b0, 1'b0);
    chk("reg0 again", 16'h0094, {8'h00, got & 8'hf5});
    regwr(1'b0, 4'h1, 8'hff);
    regrd(1'b0, 4'h1);
    chk("reg1 sep", 16'h0061, {8'h00, got});
    regwr(1'b0, 4'hf, 8'hff);
    regrd(1'b0, 4'hf);
    chk("reg15", 16'h00fa, {8'h00, got});
  endtask
  task t_shared;
    regwr(1'b1, 4'h2, 8'h5a);
    chk("vector", 16'h005a, {8'h00, VECTOR_OUT});
    regrd(1'b0, 4'h2);
    chk("vector A", 16'h005a, {8'h00, got});
    regrd(1'b1, 4'h2);
    chk("vector B", 16'h0054, {8'h00, got});
    regrd(1'b0, 4'h3);
    chk("pending A", 16'h002a, {8'h00, got});
    regrd(1'b1, 4'h3);
    chk("pending B", 16'h0000, {8'h00, got});
    regwr(1'b0, 4'h9, 8'hc1);
    chk("master", 16'h00c1, {8'h00, MASTER_CTL});
    rd(1'b1, 1'b0);
    chk("reg0 B", 16'h0064, {8'h00, got & 8'hf5});
  endtask
  task t_tx;
    wr(1'b0, 1'b1, 8'hc3);
    regwr(1'b0, 4'h8, 8'h3c);
    take(8'hc3);
    take(8'h3c);
    wr(1'b1, 1'b1, 8'h96);
    chk("TXB", 16'h0196, {7'h0, TXB_VALID, TXB_CHAR});
    TXB_READY = 1'b1;
  endtask
  task t_rx;
    push(8'h11);
    push(8'h22);
    push(8'h33);
    push(8'h44);
    repeat (3) @(negedge CLK);
    chk("rx full", 16'h0000, {15'h0, RXA_READY});
    chk("rxb ready", 16'h0001, {15'h0, RXB_READY});
    rd(1'b0, 1'b1);
    chk("rx 1", 16'h0011, {8'h00, got});
    regrd(1'b0, 4'h8);
    chk("rx 2", 16'h0022, {8'h00, got});
    rd(1'b0, 1'b1);
    chk("rx 3", 16'h0033, {8'h00, got});
    rd(1'b0, 1'b1);
    chk("rx 4", 16'h0044, {8'h00, got});
    rd(1'b0, 1'b0);
    chk("rx empty", 16'h0094, {8'h00, got & 8'hf5});
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    RSTN = 1'b0;
    {RXA_VALID, RXB_VALID, TXA_READY, TXB_READY} = 4'h0;
    {RXA_CHAR, RXB_CHAR, RXB_ERR} = 24'h0;
    RXA_ERR = 8'h61;
    MODEM_A = 4'h9;
    MODEM_B = 4'h6;
    IRQ_PENDING = 6'h2a;
    num_errors = 0;
    num_checks = 0;
    repeat (12) @(negedge CLK);
    RSTN = 1'b1;
    t_tc;
    t_ctl;
    t_shared;
    t_tx;
    t_rx;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    test_done;
  end
endmodule // dcsra_top_tb
bind dcsra_top dcsra_monitor mon (.CLK(CLK), .RSTN(RSTN), .CS_N(CS_N),
  .RD_N(RD_N), .WR_N(WR_N), .CHAN_B(CHAN_B), .DOUT(DOUT),
  .DOUT_EN(DOUT_EN), .TXA_CHAR(TXA_CHAR), .TXA_VALID(TXA_VALID),
  .TXA_READY(TXA_READY), .TC_A(TC_A), .TC_B(TC_B),
  .MASTER_CTL(MASTER_CTL), .VECTOR_OUT(VECTOR_OUT));
